// *** rtl/swpp_pkg.sv ***
// Shared constants and types for the SDRAM command model and its controller.
package swpp_pkg;
	// ==========================================================================
	// Command codes, ordered {row strobe, column strobe, write enable}.
	localparam logic [2:0] CMD_LMR = 3'h0;
	localparam logic [2:0] CMD_REF = 3'h1;
	localparam logic [2:0] CMD_PRE = 3'h2;
	localparam logic [2:0] CMD_ACT = 3'h3;
	localparam logic [2:0] CMD_WR  = 3'h4;
	localparam logic [2:0] CMD_RD  = 3'h5;
	localparam logic [2:0] CMD_BST = 3'h6;
	localparam logic [2:0] CMD_NOP = 3'h7;

	// ==========================================================================
	// Address and mode field positions, mode values after reset.
	localparam int         AB_BIT      = 10;
	localparam int         MODE_BL_LSB = 0;
	localparam int         MODE_CL_LSB = 4;
	localparam int         MODE_WBM    = 9;
	localparam logic [2:0] BL_FULL     = 3'h7;
	localparam logic [2:0] BL_RST      = 3'h3;
	localparam logic [2:0] CL_RST      = 3'h2;

	// ==========================================================================
	// Timing, in printed units and in cycles of ref_clk.
	localparam int CLK_NS      = 8;
	localparam int TWR_NS      = 15;
	localparam int TRP_NS      = 20;
	localparam int REFRESH_MS  = 64;
	localparam int TWR_CYC     = (TWR_NS + CLK_NS - 1) / CLK_NS;
	localparam int TRP_CYC     = (TRP_NS + CLK_NS - 1) / CLK_NS;
	localparam int PD_MAX_CYC  = REFRESH_MS * 1000000 / CLK_NS;
	localparam int WORDS       = 4;
	localparam int RD_GUARD    = WORDS + 3;

	// ==========================================================================
	// Controller register map and fields.
	localparam logic [7:0] REG_CMD     = 8'h00;
	localparam logic [7:0] REG_WDATA   = 8'h04;
	localparam logic [7:0] REG_CTRL    = 8'h08;
	localparam logic [7:0] REG_STAT    = 8'h0c;
	localparam int         CMD_BA_LSB  = 3;
	localparam int         CMD_AD_LSB  = 16;
	localparam logic [7:0] CTRL_RST    = 8'h01;
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ==========================================================================
	// State encodings.
	typedef enum logic [1:0] {
		DEV_RUN  = 2'h0,
		DEV_SUSP = 2'h1,
		DEV_PD   = 2'h3
	} swpp_dev_st_t;

	typedef enum logic [1:0] {
		CT_IDLE = 2'h0,
		CT_MASK = 2'h1
	} swpp_ct_st_t;
endpackage

// *** rtl/swpp_if.sv ***
// Pin bundle between the SDRAM model and its controller.
`timescale 1ns/1ps
`default_nettype none
interface swpp_if #(parameter int DW = 8);
	logic          cke;
	logic          cs_n;
	logic          ras_n;
	logic          cas_n;
	logic          we_n;
	logic [1:0]    ba;
	logic [11:0]   addr;
	logic          dqm;
	logic [DW-1:0] ctl_dq_o;
	logic          ctl_dq_oe;
	logic [DW-1:0] dev_dq_o;
	logic          dev_dq_oe;
	logic [DW-1:0] dq;

	// The device wins the shared data wire while it drives; an undriven wire reads inverted.
	assign dq = dev_dq_oe ? dev_dq_o : (ctl_dq_oe ? ctl_dq_o : ~ctl_dq_o);

	modport dev (input cke, cs_n, ras_n, cas_n, we_n, ba, addr, dqm, dq,
		output dev_dq_o, dev_dq_oe);
	modport ctl (output cke, cs_n, ras_n, cas_n, we_n, ba, addr, dqm, ctl_dq_o, ctl_dq_oe,
		input dq, dev_dq_oe);
endinterface
`default_nettype wire

// *** rtl/swpp_sdram_dev.sv ***
// Four-bank SDRAM command model: writes, truncation, precharge, power-down, suspend.
//
// What this block does
// - First write word taken with command edge.
// - Finished fixed burst ignores further data.
// - Full-page burst wraps to column zero.
// - New write truncates; its data is its own.
// - Read stops writes from its edge on.
// - Controller waits write recovery before precharge.
// - Write recovery is one clock plus time.
// - Controller masks data around truncating precharge.
// - No bank command until precharge period ends.
// - Terminate ignores its data; earlier word last.
// - All-banks bit selects one or all banks.
// - Power-down never outlasts the refresh period.
// - NOP with clock enable high exits power-down.
// - Low clock enable during burst freezes next edge.
// - Frozen edge ignores commands, holds burst, read pipe, counters; mask pipe still shifts.
// - High clock enable resumes on next edge.
// - Write burst mode bit forces single writes.
// - Other-bank read interrupts auto-precharged read.
// - Other-bank write interrupts auto-precharged read now.
// - Other-bank read interrupts auto-precharged write.
// - Other-bank write interrupts auto-precharged write.
// - Commands decode from strobes while selected.
`timescale 1ns/1ps
`default_nettype none
module swpp_sdram_dev #(
	parameter int DW = 8,
	parameter int CB = 3
) (
	// Clock and reset
	input  wire logic       ref_clk,
	input  wire logic       nrst,
	// Memory pins
	swpp_if.dev             pins,
	// Status
	output logic            pd_on,
	output logic            pd_active,
	output logic            susp_on,
	output logic [3:0]      bank_open
);
	localparam int COLS = 2 ** CB;

	typedef struct packed {
		swpp_pkg::swpp_dev_st_t       st;
		logic                         pd_act;
		logic [2:0]                   bl;
		logic [2:0]                   cl;
		logic                         wbm;
		logic [3:0]                   open;
		logic [3:0][2:0]              wr_cnt;
		logic [3:0][2:0]              pre_cnt;
		logic                         b_on;
		logic                         b_wr;
		logic                         b_ap;
		logic                         b_full;
		logic [1:0]                   b_bank;
		logic [CB-1:0]                b_col;
		logic [7:0]                   b_left;
		logic [2:0]                   pv;
		logic [2:0][DW-1:0]           pdat;
		logic                         dqm_q1;
		logic                         dqm_q2;
		logic [4*COLS-1:0][DW-1:0]    mem;
	} swpp_dev_t;

	localparam swpp_dev_t RST = '{st: swpp_pkg::DEV_RUN, bl: swpp_pkg::BL_RST,
		cl: swpp_pkg::CL_RST, default: '0};

	swpp_dev_t      r_r;
	swpp_dev_t      r_nxt;
	logic [2:0]     sel;
	logic           ab;
	logic           step;
	logic           intr;
	logic [7:0]     len;
	logic [CB+1:0]  bi;
	logic [CB+1:0]  ci;
	logic [1:0]     clx;

	always_comb begin
		r_nxt = r_r;
		// Command decode; a deselected chip sees no operation.
		sel = pins.cs_n ? swpp_pkg::CMD_NOP : {pins.ras_n, pins.cas_n, pins.we_n};
		ab = pins.addr[swpp_pkg::AB_BIT];
		bi = {r_r.b_bank, r_r.b_col};
		ci = {pins.ba, pins.addr[CB-1:0]};
		len = 8'h00;
		step = 1'b0;
		intr = 1'b0;
		r_nxt.dqm_q1 = pins.dqm;
		r_nxt.dqm_q2 = r_r.dqm_q1;
		case (r_r.st)
			swpp_pkg::DEV_PD: begin
				if (pins.cke && sel == swpp_pkg::CMD_NOP) begin
					r_nxt.st = swpp_pkg::DEV_RUN;
				end
			end
			swpp_pkg::DEV_SUSP: begin
				// Frozen edge: commands ignored, burst and read pipe held; the dqm pipe still shifts.
				if (pins.cke) begin
					r_nxt.st = swpp_pkg::DEV_RUN;
				end
			end
			swpp_pkg::DEV_RUN: begin
				// Per-bank write recovery then row precharge countdown.
				for (int b = 0; b < 4; b++) begin
					if (r_r.pre_cnt[b] != 3'h0) begin
						r_nxt.pre_cnt[b] = r_r.pre_cnt[b] - 3'h1;
					end
					if (r_r.wr_cnt[b] != 3'h0) begin
						r_nxt.wr_cnt[b] = r_r.wr_cnt[b] - 3'h1;
						if (r_r.wr_cnt[b] == 3'h1) begin
							r_nxt.open[b] = 1'b0;
							r_nxt.pre_cnt[b] = 3'(swpp_pkg::TRP_CYC);
						end
					end
				end
				r_nxt.pv = {r_r.pv[1:0], 1'b0};
				r_nxt.pdat = {r_r.pdat[1:0], {DW{1'b0}}};
				// The running burst steps unless a write, read, terminate or precharge of its bank takes the edge.
				step = r_r.b_on && !(sel == swpp_pkg::CMD_WR || sel == swpp_pkg::CMD_RD ||
					sel == swpp_pkg::CMD_BST || (sel == swpp_pkg::CMD_PRE &&
					(ab || pins.ba == r_r.b_bank)));
				if (step) begin
					if (r_r.b_wr) begin
						if (!pins.dqm) begin
							r_nxt.mem[bi] = pins.dq;
						end
					end else begin
						r_nxt.pv[0] = 1'b1;
						r_nxt.pdat[0] = r_r.mem[bi];
					end
					r_nxt.b_col = r_r.b_col + 1'b1;
					if (!r_r.b_full) begin
						r_nxt.b_left = r_r.b_left - 8'h01;
						if (r_r.b_left == 8'h01) begin
							r_nxt.b_on = 1'b0;
							if (r_r.b_ap && r_r.b_wr) begin
								r_nxt.wr_cnt[r_r.b_bank] = 3'(swpp_pkg::TWR_CYC);
							end else if (r_r.b_ap) begin
								r_nxt.open[r_r.b_bank] = 1'b0;
								r_nxt.pre_cnt[r_r.b_bank] = 3'(swpp_pkg::TRP_CYC);
							end
						end
					end
				end
				// Another bank's access ends an auto-precharged burst.
				intr = r_r.b_on && r_r.b_ap && pins.ba != r_r.b_bank &&
					(sel == swpp_pkg::CMD_WR || sel == swpp_pkg::CMD_RD);
				if (intr && r_r.b_wr) begin
					r_nxt.wr_cnt[r_r.b_bank] = 3'(swpp_pkg::TWR_CYC);
				end else if (intr) begin
					r_nxt.open[r_r.b_bank] = 1'b0;
					r_nxt.pre_cnt[r_r.b_bank] = 3'(swpp_pkg::TRP_CYC);
				end
				if (r_r.bl == swpp_pkg::BL_FULL) begin
					len = 8'h01;
				end else begin
					len = 8'h01 << r_r.bl[1:0];
				end
				case (sel)
					swpp_pkg::CMD_WR: begin
						if (!pins.dqm) begin
							r_nxt.mem[ci] = pins.dq;
						end
						// Write takes the bus: read data still queued is dropped.
						r_nxt.pv = 3'h0;
						r_nxt.b_wr = 1'b1;
						r_nxt.b_ap = ab;
						r_nxt.b_bank = pins.ba;
						r_nxt.b_col = pins.addr[CB-1:0] + 1'b1;
						r_nxt.b_full = !r_r.wbm && r_r.bl == swpp_pkg::BL_FULL;
						r_nxt.b_left = r_r.wbm ? 8'h00 : len - 8'h01;
						r_nxt.b_on = r_nxt.b_full || r_nxt.b_left != 8'h00;
						if (!r_nxt.b_on && ab) begin
							r_nxt.wr_cnt[pins.ba] = 3'(swpp_pkg::TWR_CYC);
						end
					end
					swpp_pkg::CMD_RD: begin
						r_nxt.pv[0] = 1'b1;
						r_nxt.pdat[0] = r_r.mem[ci];
						r_nxt.b_wr = 1'b0;
						r_nxt.b_ap = ab;
						r_nxt.b_bank = pins.ba;
						r_nxt.b_col = pins.addr[CB-1:0] + 1'b1;
						r_nxt.b_full = r_r.bl == swpp_pkg::BL_FULL;
						r_nxt.b_left = len - 8'h01;
						r_nxt.b_on = r_nxt.b_full || r_nxt.b_left != 8'h00;
						if (!r_nxt.b_on && ab) begin
							r_nxt.open[pins.ba] = 1'b0;
							r_nxt.pre_cnt[pins.ba] = 3'(swpp_pkg::TRP_CYC);
						end
					end
					swpp_pkg::CMD_BST: begin
						r_nxt.b_on = 1'b0;
					end
					swpp_pkg::CMD_PRE: begin
						for (int b = 0; b < 4; b++) begin
							if (ab || pins.ba == 2'(b)) begin
								r_nxt.open[b] = 1'b0;
								r_nxt.pre_cnt[b] = 3'(swpp_pkg::TRP_CYC);
							end
						end
						if (r_r.b_on && (ab || pins.ba == r_r.b_bank)) begin
							r_nxt.b_on = 1'b0;
						end
					end
					swpp_pkg::CMD_ACT: begin
						r_nxt.open[pins.ba] = 1'b1;
					end
					swpp_pkg::CMD_LMR: begin
						r_nxt.bl = pins.addr[swpp_pkg::MODE_BL_LSB +: 3];
						r_nxt.cl = pins.addr[swpp_pkg::MODE_CL_LSB +: 3];
						r_nxt.wbm = pins.addr[swpp_pkg::MODE_WBM];
					end
					default: begin
					end
				endcase
				if (!pins.cke) begin
					if (r_nxt.b_on || r_nxt.pv != 3'h0) begin
						r_nxt.st = swpp_pkg::DEV_SUSP;
					end else if (sel == swpp_pkg::CMD_NOP) begin
						r_nxt.st = swpp_pkg::DEV_PD;
						r_nxt.pd_act = |r_nxt.open;
					end
				end
			end
			default: begin
				r_nxt.st = swpp_pkg::DEV_RUN;
			end
		endcase
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			r_r <= RST;
		end else begin
			r_r <= r_nxt;
		end
	end

	// ==========================================================================
	// Outputs.
	always_comb begin
		if (r_r.cl == 3'h0) begin
			clx = 2'h0;
		end else if (r_r.cl > 3'h3) begin
			clx = 2'h2;
		end else begin
			clx = 2'(r_r.cl - 3'h1);
		end
	end

	assign pins.dev_dq_o  = r_r.pdat[clx];
	assign pins.dev_dq_oe = r_r.pv[clx] && !r_r.dqm_q2;
	assign pd_on          = r_r.st == swpp_pkg::DEV_PD;
	assign pd_active      = pd_on && r_r.pd_act;
	assign susp_on        = r_r.st == swpp_pkg::DEV_SUSP;
	assign bank_open      = r_r.open;
endmodule
`default_nettype wire

// *** rtl/swpp_ctrl.sv ***
// SDRAM command controller with an AXI4-Lite register port.
//
// The register offsets and the AXI4-Lite slave port were decided locally.
`timescale 1ns/1ps
`default_nettype none
module swpp_ctrl #(
	parameter int DW     = 8,
	parameter int PD_MAX = swpp_pkg::PD_MAX_CYC
) (
	// Clock and reset
	input  wire logic        ref_clk,
	input  wire logic        nrst,
	// AXI4-Lite slave
	input  wire logic [7:0]  s_awaddr,
	input  wire logic        s_awvalid,
	output logic             s_awready,
	input  wire logic [31:0] s_wdata,
	input  wire logic [3:0]  s_wstrb,
	input  wire logic        s_wvalid,
	output logic             s_wready,
	output logic [1:0]       s_bresp,
	output logic             s_bvalid,
	input  wire logic        s_bready,
	input  wire logic [7:0]  s_araddr,
	input  wire logic        s_arvalid,
	output logic             s_arready,
	output logic [31:0]      s_rdata,
	output logic [1:0]       s_rresp,
	output logic             s_rvalid,
	input  wire logic        s_rready,
	// Memory pins
	swpp_if.ctl              pins
);
	typedef struct packed {
		swpp_pkg::swpp_ct_st_t st;
		logic        aw_ok;
		logic        w_ok;
		logic [7:0]  awa;
		logic [31:0] wd;
		logic [3:0]  ws;
		logic        bvalid;
		logic        berr;
		logic        rvalid;
		logic        rerr;
		logic [31:0] rdata;
		logic [31:0] cmd;
		logic        pend;
		logic [31:0] wdat;
		logic [7:0]  ctrl;
		logic [DW-1:0] rcap;
		logic        rnew;
		logic        cke;
		logic        cs_n;
		logic [2:0]  op;
		logic [1:0]  ba;
		logic [11:0] addr;
		logic        dqm;
		logic [DW-1:0] dq_o;
		logic        dq_oe;
		logic [2:0]  widx;
		logic [3:0]  wr_g;
		logic [2:0]  trp_g;
		logic [3:0]  rd_g;
		logic        mcnt;
		logic [31:0] pd_cnt;
	} swpp_ct_t;

	localparam swpp_ct_t RST = '{st: swpp_pkg::CT_IDLE, cke: 1'b1, cs_n: 1'b1,
		op: swpp_pkg::CMD_NOP, ctrl: swpp_pkg::CTRL_RST, default: '0};

	swpp_ct_t    r_r;
	swpp_ct_t    r_nxt;
	logic [2:0]  kind;
	logic        ok;
	logic        go;
	logic [31:0] merged;
	logic [1:0]  wsel;
	logic        newc;

	always_comb begin
		r_nxt = r_r;
		kind = r_r.cmd[2:0];
		go = 1'b0;
		merged = 32'h0;
		wsel = 2'h0;
		newc = 1'b0;
		// Write address and data are taken in either order.
		if (s_awvalid && s_awready) begin
			r_nxt.aw_ok = 1'b1;
			r_nxt.awa = s_awaddr;
		end
		if (s_wvalid && s_wready) begin
			r_nxt.w_ok = 1'b1;
			r_nxt.wd = s_wdata;
			r_nxt.ws = s_wstrb;
		end
		if (r_r.bvalid && s_bready) begin
			r_nxt.bvalid = 1'b0;
		end
		if (r_nxt.aw_ok && r_nxt.w_ok && !r_r.bvalid) begin
			r_nxt.aw_ok = 1'b0;
			r_nxt.w_ok = 1'b0;
			r_nxt.bvalid = 1'b1;
			r_nxt.berr = 1'b0;
			for (int i = 0; i < 4; i++) begin
				merged[8*i +: 8] = r_nxt.ws[i] ? r_nxt.wd[8*i +: 8] : 8'h00;
			end
			case (r_nxt.awa)
				swpp_pkg::REG_CMD: begin
					r_nxt.cmd = merged;
					r_nxt.pend = 1'b1;
					newc = 1'b1;
				end
				swpp_pkg::REG_WDATA: r_nxt.wdat = merged;
				swpp_pkg::REG_CTRL:  r_nxt.ctrl = merged[7:0];
				default:             r_nxt.berr = 1'b1;
			endcase
		end
		if (r_r.rvalid && s_rready) begin
			r_nxt.rvalid = 1'b0;
		end
		if (s_arvalid && s_arready) begin
			r_nxt.rvalid = 1'b1;
			r_nxt.rerr = 1'b0;
			case (s_araddr)
				swpp_pkg::REG_CMD:   r_nxt.rdata = r_r.cmd;
				swpp_pkg::REG_WDATA: r_nxt.rdata = r_r.wdat;
				swpp_pkg::REG_CTRL:  r_nxt.rdata = {24'h0, r_r.ctrl};
				swpp_pkg::REG_STAT: begin
					r_nxt.rdata = {21'h0, r_r.rnew, r_r.pend, r_r.cke, 8'(r_r.rcap)};
					r_nxt.rnew = 1'b0;
				end
				default: begin
					r_nxt.rdata = 32'h0;
					r_nxt.rerr = 1'b1;
				end
			endcase
		end
		// Capture read data after the status clear so a new word is not lost.
		if (pins.dev_dq_oe) begin
			r_nxt.rcap = pins.dq;
			r_nxt.rnew = 1'b1;
		end

		// Guard timers.
		if (r_r.wr_g != 4'h0) r_nxt.wr_g = r_r.wr_g - 4'h1;
		if (r_r.trp_g != 3'h0) r_nxt.trp_g = r_r.trp_g - 3'h1;
		if (r_r.rd_g != 4'h0) r_nxt.rd_g = r_r.rd_g - 4'h1;
		// Power-down is cut short before refresh is starved.
		if (!r_r.cke) begin
			r_nxt.pd_cnt = r_r.pd_cnt + 32'h1;
			if (r_r.pd_cnt >= 32'(PD_MAX - 1)) begin
				r_nxt.ctrl[0] = 1'b1;
			end
		end else begin
			r_nxt.pd_cnt = 32'h0;
		end
		// Idle pins: deselected, which also exits power-down.
		r_nxt.cke = r_nxt.ctrl[0];
		r_nxt.cs_n = 1'b1;
		r_nxt.op = swpp_pkg::CMD_NOP;
		r_nxt.dq_oe = r_r.widx != 3'h0;
		r_nxt.dqm = 1'b0;
		if (r_r.widx != 3'h0) begin
			wsel = 2'(swpp_pkg::WORDS - 32'(r_r.widx));
			r_nxt.dq_o = DW'(r_r.wdat[8*wsel +: 8]);
			r_nxt.dqm = r_r.ctrl[1 + wsel];
			r_nxt.widx = r_r.widx - 3'h1;
		end
		ok = r_r.pend && r_r.cke && r_nxt.cke && r_r.trp_g == 3'h0 &&
			!(kind == swpp_pkg::CMD_PRE && r_r.wr_g != 4'h0);
		case (r_r.st)
			swpp_pkg::CT_IDLE: begin
				if (ok && (kind == swpp_pkg::CMD_PRE ||
					(kind == swpp_pkg::CMD_WR && r_r.rd_g != 4'h0))) begin
					r_nxt.st = swpp_pkg::CT_MASK;
					r_nxt.mcnt = kind == swpp_pkg::CMD_WR;
					r_nxt.dqm = 1'b1;
					r_nxt.dq_oe = 1'b0;
					r_nxt.widx = 3'h0;
				end else if (ok) begin
					go = 1'b1;
				end
			end
			swpp_pkg::CT_MASK: begin
				r_nxt.dqm = 1'b1;
				r_nxt.dq_oe = 1'b0;
				r_nxt.widx = 3'h0;
				if (r_r.mcnt) begin
					r_nxt.mcnt = 1'b0;
				end else if (r_nxt.cke) begin
					go = 1'b1;
					r_nxt.st = swpp_pkg::CT_IDLE;
				end
			end
			default: r_nxt.st = swpp_pkg::CT_IDLE;
		endcase
		if (go) begin
			r_nxt.pend = newc;
			r_nxt.cs_n = 1'b0;
			r_nxt.op = kind;
			r_nxt.ba = r_r.cmd[swpp_pkg::CMD_BA_LSB +: 2];
			r_nxt.addr = r_r.cmd[swpp_pkg::CMD_AD_LSB +: 12];
			if (kind == swpp_pkg::CMD_WR) begin
				r_nxt.dq_o = DW'(r_r.wdat[7:0]);
				r_nxt.dq_oe = 1'b1;
				r_nxt.dqm = r_r.ctrl[1];
				r_nxt.widx = 3'(swpp_pkg::WORDS - 1);
				r_nxt.wr_g = 4'(swpp_pkg::WORDS - 1 + swpp_pkg::TWR_CYC);
			end
			if (kind == swpp_pkg::CMD_RD) begin
				r_nxt.rd_g = 4'(swpp_pkg::RD_GUARD);
			end
			if (kind == swpp_pkg::CMD_PRE) begin
				r_nxt.dqm = 1'b1;
				r_nxt.trp_g = 3'(swpp_pkg::TRP_CYC);
			end
		end
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			r_r <= RST;
		end else begin
			r_r <= r_nxt;
		end
	end

	// ==========================================================================
	// Outputs.
	assign s_awready      = !r_r.aw_ok && !r_r.bvalid;
	assign s_wready       = !r_r.w_ok && !r_r.bvalid;
	assign s_bvalid       = r_r.bvalid;
	assign s_bresp        = r_r.berr ? swpp_pkg::RESP_SLVERR : swpp_pkg::RESP_OKAY;
	assign s_arready      = !r_r.rvalid;
	assign s_rvalid       = r_r.rvalid;
	assign s_rdata        = r_r.rdata;
	assign s_rresp        = r_r.rerr ? swpp_pkg::RESP_SLVERR : swpp_pkg::RESP_OKAY;
	assign pins.cke       = r_r.cke;
	assign pins.cs_n      = r_r.cs_n;
	assign pins.ras_n     = r_r.op[2];
	assign pins.cas_n     = r_r.op[1];
	assign pins.we_n      = r_r.op[0];
	assign pins.ba        = r_r.ba;
	assign pins.addr      = r_r.addr;
	assign pins.dqm       = r_r.dqm;
	assign pins.ctl_dq_o  = r_r.dq_o;
	assign pins.ctl_dq_oe = r_r.dq_oe;
endmodule
`default_nettype wire

// *** dv/swpp_props.sv ***
// Pin-level checker for the controller-to-SDRAM bundle.
`timescale 1ns/1ps
`default_nettype none
module swpp_props #(
	parameter int DW     = 8,
	parameter int PD_MAX = 64
) (
	// Clock and reset
	input wire logic          ref_clk,
	input wire logic          nrst,
	// Command pins
	input wire logic          cke,
	input wire logic          cs_n,
	input wire logic          ras_n,
	input wire logic          cas_n,
	input wire logic          we_n,
	input wire logic [1:0]    ba,
	input wire logic [11:0]   addr,
	input wire logic          dqm,
	// Data pins
	input wire logic [DW-1:0] ctl_dq_o,
	input wire logic          ctl_dq_oe,
	input wire logic [DW-1:0] dev_dq_o,
	input wire logic          dev_dq_oe
);
	typedef struct packed {
		logic [3:0]  rd_age;
		logic [31:0] low_cnt;
	} swpp_chk_st_t;
	swpp_chk_st_t st_r;
	swpp_chk_st_t st_nxt;
	logic [2:0]   cmd;
	logic         is_wr;
	logic         is_rd;
	logic         is_pre;
	logic         is_idle;

	assign cmd     = {ras_n, cas_n, we_n};
	assign is_idle = cs_n || cmd == swpp_pkg::CMD_NOP;
	assign is_wr   = cke && !cs_n && cmd == swpp_pkg::CMD_WR;
	assign is_rd   = cke && !cs_n && cmd == swpp_pkg::CMD_RD;
	assign is_pre  = cke && !cs_n && cmd == swpp_pkg::CMD_PRE;

	// Cycles since the last read, and length of the current clock-enable low spell.
	always_comb begin
		st_nxt = st_r;
		st_nxt.rd_age = is_rd ? 4'h1 : (st_r.rd_age == 4'hf ? 4'hf : st_r.rd_age + 4'h1);
		st_nxt.low_cnt = cke ? 32'h0 : st_r.low_cnt + 32'h1;
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			st_r <= '{rd_age: 4'hf, low_cnt: 32'h0};
		end else begin
			st_r <= st_nxt;
		end
	end

	default clocking @(posedge ref_clk); endclocking
	default disable iff (!nrst);

	chk_wr_data_coinc: assert property (is_wr |-> ctl_dq_oe && !dev_dq_oe)
		else $error("write command without its first data word");
	chk_wr_burst_four: assert property (is_wr |-> ctl_dq_oe [*4])
		else $error("write data not driven for four cycles");
	chk_pre_wr_gap: assert property (is_wr |=> !is_pre [*4])
		else $error("precharge inside write recovery");
	chk_pre_mask: assert property (is_pre |-> dqm && $past(dqm))
		else $error("precharge without byte mask around it");
	chk_pre_quiet: assert property (is_pre |=> is_idle [*2])
		else $error("command inside row precharge period");
	chk_rd_data_lat: assert property (is_rd && !dqm |-> ##2 dev_dq_oe)
		else $error("read data not driven after read latency");
	chk_dev_drive_cause: assert property ($rose(dev_dq_oe) |-> $past(is_rd, 2))
		else $error("device drives data without a read");
	chk_pd_nop: assert property (!cke || $rose(cke) |-> is_idle)
		else $error("command issued while clock enable low or on exit");
	chk_pd_bound: assert property (st_r.low_cnt <= PD_MAX + 2)
		else $error("power-down held beyond its limit");
	chk_wr_rd_mask: assert property (is_wr && st_r.rd_age <= 4'h5 |-> $past(dqm) && $past(dqm, 2))
		else $error("write after read without two masked cycles");

	cover property (is_wr);
	cover property (is_pre && addr[swpp_pkg::AB_BIT]);
	cover property ($fell(cke));
endmodule
`default_nettype wire

// *** dv/test_sdram_write_precharge_power.sv ***
// Self-checking bench: controller and SDRAM model joined through the pin bundle.
`timescale 1ns/1ps
`default_nettype none
`define SWPP_CHK(nm, exp, got) begin check_count++; if ((got) !== (exp)) begin \
	$display("MISMATCH %s expected %0h seen %0h", nm, exp, got); n_errors++; end end
module test_sdram_write_precharge_power;
	logic        ref_clk;
	logic        nrst;
	logic [7:0]  s_awaddr;
	logic        s_awvalid;
	logic        s_awready;
	logic [31:0] s_wdata;
	logic [3:0]  s_wstrb;
	logic        s_wvalid;
	logic        s_wready;
	logic [1:0]  s_bresp;
	logic        s_bvalid;
	logic        s_bready;
	logic [7:0]  s_araddr;
	logic        s_arvalid;
	logic        s_arready;
	logic [31:0] s_rdata;
	logic [1:0]  s_rresp;
	logic        s_rvalid;
	logic        s_rready;
	logic        pd_on;
	logic        pd_active;
	logic        susp_on;
	logic [3:0]  bank_open;
	int          n_errors;
	int          check_count;

	swpp_if bus ();
	swpp_sdram_dev i_swpp_sdram_dev (.ref_clk(ref_clk), .nrst(nrst),
		.pins(bus), .pd_on(pd_on), .pd_active(pd_active), .susp_on(susp_on),
		.bank_open(bank_open));
	swpp_ctrl #(.PD_MAX(64)) i_swpp_ctrl (.ref_clk(ref_clk), .nrst(nrst),
		.s_awaddr(s_awaddr), .s_awvalid(s_awvalid), .s_awready(s_awready), .s_wdata(s_wdata),
		.s_wstrb(s_wstrb), .s_wvalid(s_wvalid), .s_wready(s_wready), .s_bresp(s_bresp),
		.s_bvalid(s_bvalid), .s_bready(s_bready), .s_araddr(s_araddr), .s_arvalid(s_arvalid),
		.s_arready(s_arready), .s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid),
		.s_rready(s_rready), .pins(bus));
	swpp_props i_swpp_props (.ref_clk(ref_clk), .nrst(nrst),
		.cke(bus.cke), .cs_n(bus.cs_n), .ras_n(bus.ras_n), .cas_n(bus.cas_n), .we_n(bus.we_n),
		.ba(bus.ba), .addr(bus.addr), .dqm(bus.dqm), .ctl_dq_o(bus.ctl_dq_o),
		.ctl_dq_oe(bus.ctl_dq_oe), .dev_dq_o(bus.dev_dq_o), .dev_dq_oe(bus.dev_dq_oe));

	task automatic tally_and_finish();
		$display("Checks %0d, mismatches %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	task automatic hang_guard(input int n);
		if (n > 200) begin
			$display("MISMATCH wait expected done seen timeout");
			n_errors++;
			tally_and_finish();
		end
	endtask

	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] resp);
		int n;
		n = 0;
		@(posedge ref_clk);
		s_awaddr <= a;
		s_awvalid <= 1'b1;
		s_wdata <= d;
		s_wvalid <= 1'b1;
		s_bready <= 1'b1;
		do begin
			@(posedge ref_clk);
			n++;
			hang_guard(n);
			if (s_awvalid && s_awready) s_awvalid <= 1'b0;
			if (s_wvalid && s_wready) s_wvalid <= 1'b0;
		end while (!s_bvalid);
		resp = s_bresp;
		s_bready <= 1'b0;
	endtask

	task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
		int n;
		n = 0;
		@(posedge ref_clk);
		s_araddr <= a;
		s_arvalid <= 1'b1;
		s_rready <= 1'b1;
		do begin
			@(posedge ref_clk);
			n++;
			hang_guard(n);
			if (s_arvalid && s_arready) s_arvalid <= 1'b0;
		end while (!s_rvalid);
		d = s_rdata;
		resp = s_rresp;
		s_rready <= 1'b0;
	endtask

	// Posts a command and waits until the sequencer has put it on the pins.
	task automatic cmd(input logic [2:0] code, input logic [1:0] b, input logic [11:0] ad,
		output logic [31:0] st);
		logic [1:0] r;
		int         n;
		axi_wr(swpp_pkg::REG_CMD, {4'h0, ad, 11'h000, b, code}, r);
		n = 0;
		do begin
			axi_rd(swpp_pkg::REG_STAT, st, r);
			n++;
			hang_guard(n);
		end while (st[9]);
	endtask

	task automatic set_mode(input logic wbm, input logic [2:0] bl);
		logic [31:0] st;
		cmd(swpp_pkg::CMD_LMR, 2'h0, {2'h0, wbm, 2'h0, 3'h2, 1'h0, bl}, st);
	endtask

	// Writes one burst to column 0 of bank 0, then returns to single-word reads.
	task automatic wr_burst(input logic [2:0] bl, input logic wbm, input logic [31:0] d);
		logic [31:0] st;
		logic [1:0]  r;
		set_mode(wbm, bl);
		axi_wr(swpp_pkg::REG_WDATA, d, r);
		cmd(swpp_pkg::CMD_WR, 2'h0, 12'h000, st);
		set_mode(1'b0, 3'h0);
	endtask

	task automatic rd_chk(input logic [2:0] col, input logic [7:0] exp);
		logic [31:0] st;
		logic [1:0]  r;
		int          n;
		cmd(swpp_pkg::CMD_RD, 2'h0, {9'h000, col}, st);
		n = 0;
		while (!st[10]) begin
			axi_rd(swpp_pkg::REG_STAT, st, r);
			n++;
			hang_guard(n);
		end
		`SWPP_CHK("rd_col", exp, st[7:0])
	endtask

	task automatic wait_pd(input logic v);
		int n;
		n = 0;
		while (pd_on !== v && n < 100) begin
			@(posedge ref_clk);
			n++;
		end
		`SWPP_CHK("pd_on", v, pd_on)
	endtask

	task automatic rd_wr_chk();
		logic [31:0] st;
		logic [1:0]  r;
		axi_wr(swpp_pkg::REG_WDATA, 32'h5a, r);
		axi_wr(swpp_pkg::REG_CMD, {29'h0, swpp_pkg::CMD_RD}, r);
		cmd(swpp_pkg::CMD_WR, 2'h0, 12'h000, st);
		`SWPP_CHK("rd_before_wr", 8'h00, st[7:0])
		rd_chk(3'h0, 8'h5a);
	endtask

	task automatic susp_chk();
		logic [31:0] st;
		logic [1:0]  r;
		wr_burst(3'h7, 1'b0, 32'h0);
		axi_wr(swpp_pkg::REG_CTRL, 32'h0, r);
		@(posedge ref_clk);
		`SWPP_CHK("susp_on", 1'b1, susp_on)
		axi_wr(swpp_pkg::REG_CTRL, 32'h1, r);
		@(posedge ref_clk);
		`SWPP_CHK("susp_on", 1'b0, susp_on)
		cmd(swpp_pkg::CMD_BST, 2'h0, 12'h000, st);
	endtask

	initial begin
		ref_clk = 1'b0;
		forever begin
			#4 ref_clk = ~ref_clk;
		end
	end

	initial begin
		logic [31:0] st;
		logic [1:0]  r;
		n_errors = 0;
		check_count = 0;
		nrst = 1'b0;
		s_awaddr = 8'h00;
		s_awvalid = 1'b0;
		s_wdata = 32'h0;
		s_wstrb = 4'hf;
		s_wvalid = 1'b0;
		s_bready = 1'b0;
		s_araddr = 8'h00;
		s_arvalid = 1'b0;
		s_rready = 1'b0;
		repeat (6) @(posedge ref_clk);
		nrst <= 1'b1;
		axi_wr(8'h40, 32'h0, r);
		`SWPP_CHK("unmapped_wr", swpp_pkg::RESP_SLVERR, r)
		axi_rd(8'h40, st, r);
		`SWPP_CHK("unmapped_rd", swpp_pkg::RESP_SLVERR, r)
		cmd(swpp_pkg::CMD_ACT, 2'h0, 12'h000, st);
		wr_burst(3'h2, 1'b0, 32'h44332211);
		for (int k = 0; k < 4; k++) begin
			rd_chk(3'(k), 8'(17 * (k + 1)));
		end
		wr_burst(3'h1, 1'b0, 32'hddccbbaa);
		rd_chk(3'h1, 8'hbb);
		rd_chk(3'h2, 8'h33);
		wr_burst(3'h2, 1'b1, 32'h99887766);
		rd_chk(3'h0, 8'h66);
		rd_chk(3'h1, 8'hbb);
		cmd(swpp_pkg::CMD_ACT, 2'h1, 12'h000, st);
		`SWPP_CHK("bank_open", 4'h3, bank_open)
		cmd(swpp_pkg::CMD_PRE, 2'h1, 12'h000, st);
		`SWPP_CHK("bank_open", 4'h1, bank_open)
		wr_burst(3'h2, 1'b0, 32'h0);
		cmd(swpp_pkg::CMD_PRE, 2'h2, 12'h400, st);
		`SWPP_CHK("bank_open", 4'h0, bank_open)
		axi_wr(swpp_pkg::REG_CTRL, 32'h0, r);
		wait_pd(1'b1);
		`SWPP_CHK("pd_active", 1'b0, pd_active)
		axi_wr(swpp_pkg::REG_CTRL, 32'h1, r);
		wait_pd(1'b0);
		cmd(swpp_pkg::CMD_ACT, 2'h0, 12'h000, st);
		axi_wr(swpp_pkg::REG_CTRL, 32'h0, r);
		wait_pd(1'b1);
		`SWPP_CHK("pd_active", 1'b1, pd_active)
		wait_pd(1'b0);
		axi_rd(swpp_pkg::REG_CTRL, st, r);
		`SWPP_CHK("cke_forced", 1'b1, st[0])
		rd_wr_chk();
		susp_chk();
		tally_and_finish();
	end
endmodule
`default_nettype wire
